/* File: rtl/hpc_host_port_regs.sv */
`timescale 1ns/1ps
`include "hpc_regs.svh"
// Behaviour
// - identification register is read-only: device code bits 7-0, revision bits 15-8.
// - indices 04H through 1CH are reserved and implement nothing.
// - select bit clear limits write bursts to 8; set uses field bits 7-6.
// - write length field: 00=1, 01=2, 10=4, 11=6 doublewords; reset 11.
// - read length field bits 9-8: 00=2, 01=4, 10=8, 11=unlimited; reset 11.
// - bit 10 puts line-sync before (0) or after (1) lines, non-video reads.
// - bit 11 lets internal interrupts assert the active-low PCI interrupt.
// - bit 12 lets the external interrupt input assert the PCI interrupt.
// - bits 15-13 route internal interrupt: none, A, B, C, D (10x), E (11x).
// - at most one legacy interrupt line is asserted at any time.
// - writing one to bit 16 of soft reset register resets the device.
// - clock drive bit 0 drives clock line low at zero, releases at one.
// - data drive bit 1 drives data line low at zero, releases at one.
// - read-only bit 2 returns sampled clock line level.
// - read-only bit 3 returns sampled data line level.
// - enable bit 4 gates bits 3-0; clear means no effect on pins.
// - three address bytes highest first, then four data bytes lowest first.
module hpc_host_port_regs
#(
   parameter logic [7:0] DEVICE_CODE   = 8'h5a, // arbitrary value
   parameter logic [7:0] REVISION_CODE = 8'h01  // arbitrary value
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       hp_byte_valid,
   input  wire logic [7:0] hp_byte_data,
   output logic            hp_rd_valid,
   output logic [7:0]      hp_rd_data,
   output logic            hp_busy,
   input  wire logic       internal_irq,
   input  wire logic       external_irq_input,
   output logic            pci_irq_n,
   output logic            legacy_irq_line_a,
   output logic            legacy_irq_line_b,
   output logic            legacy_irq_line_c,
   output logic            legacy_irq_line_d,
   output logic            legacy_irq_line_e,
   output logic [3:0]      write_burst_limit,
   output logic [3:0]      read_burst_limit,
   output logic            line_sync_placement,
   output logic            soft_reset_pulse,
   input  wire logic       twowire_clock_in,
   output logic            twowire_clock_out,
   output logic            twowire_clock_oe,
   input  wire logic       twowire_data_in,
   output logic            twowire_data_out,
   output logic            twowire_data_oe
);

   hpc_pkg::hpc_state_e state_r;
   logic [23:0]         addr_r;
   logic [31:0]         wdata_r;
   logic [1:0]          cnt_r;
   logic [31:0]         rdata_r;
   logic [31:0]         ctrl_r;
   logic [4:0]          twi_r;
   logic                srst_r;
   logic                ext_meta_r;
   logic                ext_sync_r;
   logic                scl_meta_r;
   logic                scl_sync_r;
   logic                sda_meta_r;
   logic                sda_sync_r;
   logic [10:0]         reg_ofs;
   logic                is_reg;
   logic                is_write;
   logic                is_read;
   logic                wr_commit;
   logic [31:0]         byte_keep;
   logic [31:0]         ctrl_nxt;
   logic [4:0]          twi_nxt;
   logic [31:0]         read_word;
   logic [2:0]          lsel;
   logic                twi_en;

   // address word fields decoded from the collected header
   assign reg_ofs  = addr_r[10:0];
   assign is_reg   = addr_r[`HPC_AW_REG];
   assign is_write = addr_r[23:`HPC_AW_CMD_LSB] == `HPC_CMD_WRITE;
   assign is_read  = addr_r[23:`HPC_AW_CMD_LSB] == `HPC_CMD_READ;
   assign hp_busy  = state_r == hpc_pkg::HPC_RDATA;

   // commit happens when the fourth data byte arrives
   assign wr_commit = (state_r == hpc_pkg::HPC_WDATA) && hp_byte_valid && (cnt_r == 2'h3)
                      && is_reg && is_write;

   // a set disable bit keeps the old byte
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         byte_keep[i*8 +: 8] = {8{addr_r[16+i]}};
      end
   end

   // header then data sequencing; memory accesses are swallowed
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= hpc_pkg::HPC_ADDR_HI;
         cnt_r   <= 2'h0;
      end
      else if (srst_r)
      begin
         state_r <= hpc_pkg::HPC_ADDR_HI;
         cnt_r   <= 2'h0;
      end
      else
      begin
         unique case (state_r)
            hpc_pkg::HPC_ADDR_HI:
            begin
               if (hp_byte_valid)
               begin
                  state_r <= hpc_pkg::HPC_ADDR_MID;
               end
            end
            hpc_pkg::HPC_ADDR_MID:
            begin
               if (hp_byte_valid)
               begin
                  state_r <= hpc_pkg::HPC_ADDR_LO;
               end
            end
            hpc_pkg::HPC_ADDR_LO:
            begin
               if (hp_byte_valid)
               begin
                  cnt_r <= 2'h0;
                  if (addr_r[23:`HPC_AW_CMD_LSB] == `HPC_CMD_READ)
                  begin
                     state_r <= hpc_pkg::HPC_RDATA;
                  end
                  else
                  begin
                     state_r <= hpc_pkg::HPC_WDATA;
                  end
               end
            end
            hpc_pkg::HPC_WDATA:
            begin
               if (hp_byte_valid)
               begin
                  cnt_r <= cnt_r + 2'h1;
                  if (cnt_r == 2'h3)
                  begin
                     state_r <= hpc_pkg::HPC_ADDR_HI;
                  end
               end
            end
            hpc_pkg::HPC_RDATA:
            begin
               cnt_r <= cnt_r + 2'h1;
               if (cnt_r == 2'h3)
               begin
                  state_r <= hpc_pkg::HPC_ADDR_HI;
               end
            end
            default:
            begin
               state_r <= hpc_pkg::HPC_ADDR_HI;
            end
         endcase
      end
   end

   // header bytes arrive highest first
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         addr_r <= 24'h000000;
      end
      else if (hp_byte_valid)
      begin
         unique case (state_r)
            hpc_pkg::HPC_ADDR_HI:  addr_r[23:16] <= hp_byte_data;
            hpc_pkg::HPC_ADDR_MID: addr_r[15:8]  <= hp_byte_data;
            hpc_pkg::HPC_ADDR_LO:  addr_r[7:0]   <= hp_byte_data;
            default:               addr_r        <= addr_r;
         endcase
      end
   end

   // data bytes arrive lowest first
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wdata_r <= 32'h00000000;
      end
      else if (hp_byte_valid && state_r == hpc_pkg::HPC_WDATA)
      begin
         wdata_r[cnt_r*8 +: 8] <= hp_byte_data;
      end
   end

   // read mux; reserved and unmapped space reads zero
   always_comb
   begin
      read_word = 32'h00000000;
      if (is_reg)
      begin
         unique case (reg_ofs)
            `HPC_OFS_ID:
               read_word = {16'h0000, REVISION_CODE, DEVICE_CODE};
            `HPC_OFS_CTRL:
               read_word = ctrl_r | `HPC_CTRL_FIXED;
            `HPC_OFS_TWI:
               read_word = {27'h0000000, twi_r[4], twi_en & sda_sync_r,
                            twi_en & scl_sync_r, twi_r[1:0]};
            default:
               read_word = 32'h00000000;
         endcase
      end
   end

   // word latched in the first read cycle after the header, then shifted out
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdata_r     <= 32'h00000000;
         hp_rd_valid <= 1'b0;
         hp_rd_data  <= 8'h00;
      end
      else
      begin
         hp_rd_valid <= state_r == hpc_pkg::HPC_RDATA;
         // first byte comes straight from the mux; the word is latched only now
         if (state_r == hpc_pkg::HPC_RDATA && cnt_r == 2'h0)
         begin
            hp_rd_data <= read_word[7:0];
         end
         else if (state_r == hpc_pkg::HPC_RDATA)
         begin
            hp_rd_data <= rdata_r[cnt_r*8 +: 8];
         end
         if (state_r == hpc_pkg::HPC_ADDR_LO && hp_byte_valid)
         begin
            rdata_r <= 32'h00000000;
         end
         else if (state_r == hpc_pkg::HPC_RDATA && cnt_r == 2'h0)
         begin
            rdata_r <= read_word;
         end
      end
   end

   // next control value honouring byte disables; reserved bits dropped
   assign ctrl_nxt = ((ctrl_r & byte_keep) | (wdata_r_next() & ~byte_keep))
                     & `HPC_CTRL_WMASK;

   function automatic logic [31:0] wdata_r_next();
      logic [31:0] w;
      w = wdata_r;
      w[31:24] = hp_byte_data;
      return w;
   endfunction

   assign twi_nxt = {ctrl_nxt[0] & 1'b0, 4'h0} | {((twi_r[4] & byte_keep[4]) |
                    (wdata_r[4] & ~byte_keep[4])), 2'h0,
                    (twi_r[1] & byte_keep[1]) | (wdata_r[1] & ~byte_keep[1]),
                    (twi_r[0] & byte_keep[0]) | (wdata_r[0] & ~byte_keep[0])};

   // control register, loaded with its reset value by power-on or soft reset
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r <= `HPC_CTRL_RESET & `HPC_CTRL_WMASK;
      end
      else if (srst_r)
      begin
         ctrl_r <= `HPC_CTRL_RESET & `HPC_CTRL_WMASK;
      end
      else if (wr_commit && reg_ofs == `HPC_OFS_CTRL)
      begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // two-wire control bits; sample bits are not storage
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         twi_r <= `HPC_TWI_RESET;
      end
      else if (srst_r)
      begin
         twi_r <= `HPC_TWI_RESET;
      end
      else if (wr_commit && reg_ofs == `HPC_OFS_TWI)
      begin
         twi_r <= twi_nxt;
      end
   end

   // soft reset strobe; the bit itself never stores, so reads give zero
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         srst_r <= 1'b0;
      end
      else
      begin
         srst_r <= wr_commit && reg_ofs == `HPC_OFS_SRST && !byte_keep[`HPC_SRST_BIT]
                   && wdata_r[`HPC_SRST_BIT];
      end
   end
   assign soft_reset_pulse = srst_r;

   // pins from outside pass two flops before use
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
         scl_meta_r <= 1'b1;
         scl_sync_r <= 1'b1;
         sda_meta_r <= 1'b1;
         sda_sync_r <= 1'b1;
      end
      else
      begin
         ext_meta_r <= external_irq_input;
         ext_sync_r <= ext_meta_r;
         scl_meta_r <= twowire_clock_in;
         scl_sync_r <= scl_meta_r;
         sda_meta_r <= twowire_data_in;
         sda_sync_r <= sda_meta_r;
      end
   end

   assign lsel   = ctrl_r[`HPC_CTRL_LSEL_LSB +: 3];
   assign twi_en = twi_r[`HPC_TWI_EN];

   // interrupt routing; one-hot legacy decode keeps a single line active
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pci_irq_n         <= 1'b1;
         legacy_irq_line_a <= 1'b0;
         legacy_irq_line_b <= 1'b0;
         legacy_irq_line_c <= 1'b0;
         legacy_irq_line_d <= 1'b0;
         legacy_irq_line_e <= 1'b0;
      end
      else
      begin
         pci_irq_n <= !((internal_irq && ctrl_r[`HPC_CTRL_IPCI])
                        || (ext_sync_r && ctrl_r[`HPC_CTRL_EPCI]));
         legacy_irq_line_a <= internal_irq && lsel == 3'h1;
         legacy_irq_line_b <= internal_irq && lsel == 3'h2;
         legacy_irq_line_c <= internal_irq && lsel == 3'h3;
         legacy_irq_line_d <= internal_irq && lsel[2:1] == 2'h2;
         legacy_irq_line_e <= internal_irq && lsel[2:1] == 2'h3;
      end
   end

   // burst limits decoded into doubleword counts for the transfer engine
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         write_burst_limit   <= `HPC_WBL_FIXED;  // select bit is clear after reset
         read_burst_limit    <= `HPC_RBL_UNLIM;
         line_sync_placement <= 1'b1;
      end
      else
      begin
         if (!ctrl_r[`HPC_CTRL_BSEL])
         begin
            write_burst_limit <= `HPC_WBL_FIXED;
         end
         else
         begin
            unique case (ctrl_r[`HPC_CTRL_WBL_LSB +: 2])
               2'h0: write_burst_limit <= `HPC_WBL_00;
               2'h1: write_burst_limit <= `HPC_WBL_01;
               2'h2: write_burst_limit <= `HPC_WBL_10;
               2'h3: write_burst_limit <= `HPC_WBL_11;
            endcase
         end
         unique case (ctrl_r[`HPC_CTRL_RBL_LSB +: 2])
            2'h0: read_burst_limit <= `HPC_RBL_00;
            2'h1: read_burst_limit <= `HPC_RBL_01;
            2'h2: read_burst_limit <= `HPC_RBL_10;
            2'h3: read_burst_limit <= `HPC_RBL_UNLIM;
         endcase
         line_sync_placement <= ctrl_r[`HPC_CTRL_LSYNC];
      end
   end

   // open-drain lines only ever pull low; disabled port stays released
   assign twowire_clock_out = 1'b0;
   assign twowire_data_out  = 1'b0;
   assign twowire_clock_oe  = twi_en && !twi_r[`HPC_TWI_CDRV];
   assign twowire_data_oe   = twi_en && !twi_r[`HPC_TWI_DDRV];

endmodule

/* File: rtl/hpc_regs.svh */
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH

// register offsets within the 11-bit register space
`define HPC_OFS_ID          11'h000
`define HPC_OFS_CTRL        11'h020
`define HPC_OFS_SRST        11'h034
`define HPC_OFS_TWI         11'h060
`define HPC_OFS_RSV_LO      11'h004
`define HPC_OFS_RSV_HI      11'h01c

// identification fields
`define HPC_ID_DEV_LSB      0
`define HPC_ID_REV_LSB      8

// control register fields
`define HPC_CTRL_BSEL       0
`define HPC_CTRL_WBL_LSB    6
`define HPC_CTRL_RBL_LSB    8
`define HPC_CTRL_LSYNC      10
`define HPC_CTRL_IPCI       11
`define HPC_CTRL_EPCI       12
`define HPC_CTRL_LSEL_LSB   13
`define HPC_CTRL_RESET      32'h000107c8
`define HPC_CTRL_FIXED      32'h00010008
`define HPC_CTRL_WMASK      32'h0000ffc1

// soft reset register
`define HPC_SRST_BIT        16

// two-wire port register fields
`define HPC_TWI_CDRV        0
`define HPC_TWI_DDRV        1
`define HPC_TWI_CSMP        2
`define HPC_TWI_DSMP        3
`define HPC_TWI_EN          4
`define HPC_TWI_RESET       5'h00

// address word fields
`define HPC_AW_REG          20
`define HPC_AW_CMD_LSB      21
`define HPC_CMD_WRITE       3'h0
`define HPC_CMD_READ        3'h1

// burst limits in doublewords
`define HPC_WBL_FIXED       4'h8
`define HPC_WBL_00          4'h1
`define HPC_WBL_01          4'h2
`define HPC_WBL_10          4'h4
`define HPC_WBL_11          4'h6
`define HPC_RBL_00          4'h2
`define HPC_RBL_01          4'h4
`define HPC_RBL_10          4'h8
`define HPC_RBL_UNLIM       4'h0

`endif

/* File: rtl/hpc_pkg.sv */
package hpc_pkg;

   // host port transfer sequencing
   typedef enum logic [2:0]
   {
      HPC_ADDR_HI,
      HPC_ADDR_MID,
      HPC_ADDR_LO,
      HPC_WDATA,
      HPC_RDATA
   } hpc_state_e;

   typedef logic [7:0] hpc_byte_t;

endpackage

/* File: tb/hpc_regs_props.sv */
`timescale 1ns/1ps
module hpc_regs_props
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       internal_irq,
   input wire logic       external_irq_input,
   input wire logic       pci_irq_n,
   input wire logic       legacy_irq_line_a,
   input wire logic       legacy_irq_line_b,
   input wire logic       legacy_irq_line_c,
   input wire logic       legacy_irq_line_d,
   input wire logic       legacy_irq_line_e,
   input wire logic [3:0] write_burst_limit,
   input wire logic [3:0] read_burst_limit,
   input wire logic       line_sync_placement,
   input wire logic       soft_reset_pulse,
   input wire logic       hp_rd_valid,
   input wire logic       hp_busy,
   input wire logic       twowire_clock_out,
   input wire logic       twowire_data_out
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // legacy lines gathered, line a in bit 0
   wire logic [4:0] leg = {legacy_irq_line_e, legacy_irq_line_d, legacy_irq_line_c,
                           legacy_irq_line_b, legacy_irq_line_a};
   wire logic       ext = external_irq_input;

   chk_legacy_one_hot: assert property ($onehot0(leg))
      else $error("more than one legacy line high");
   chk_legacy_idle: assert property (!$past(internal_irq) |-> leg == 5'h00)
      else $error("legacy line high without internal interrupt");
   chk_pci_idle: assert property (
      !$past(internal_irq) && !$past(ext, 3) |-> pci_irq_n)
      else $error("pci interrupt low without a cause");
   chk_srst_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse longer than one cycle");
   chk_srst_restore: assert property (soft_reset_pulse |-> ##2
      write_burst_limit == 4'h8 && read_burst_limit == 4'h0 && line_sync_placement)
      else $error("limits not back to reset values after soft reset");
   chk_rd_four_bytes: assert property (
      $rose(hp_rd_valid) |-> hp_rd_valid[*4] ##1 !hp_rd_valid)
      else $error("read data not four consecutive bytes");
   chk_rd_in_busy: assert property (hp_rd_valid |-> hp_busy || $past(hp_busy))
      else $error("read byte outside busy window");
   chk_wbl_coded: assert property (
      write_burst_limit inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
      else $error("write burst limit not a coded value");
   chk_rbl_coded: assert property (read_burst_limit inside {4'h0, 4'h2, 4'h4, 4'h8})
      else $error("read burst limit not a coded value");
   chk_twi_drive_low: assert property (!twowire_clock_out && !twowire_data_out)
      else $error("two-wire line driven high");

   cover property ($rose(hp_rd_valid));
   cover property (soft_reset_pulse);
   cover property (legacy_irq_line_e);
   cover property (!pci_irq_n);
endmodule

bind hpc_host_port_regs hpc_regs_props chk_u
(
   .clk_sys(clk_sys), .rst(rst), .internal_irq(internal_irq),
   .external_irq_input(external_irq_input), .pci_irq_n(pci_irq_n),
   .legacy_irq_line_a(legacy_irq_line_a), .legacy_irq_line_b(legacy_irq_line_b),
   .legacy_irq_line_c(legacy_irq_line_c), .legacy_irq_line_d(legacy_irq_line_d),
   .legacy_irq_line_e(legacy_irq_line_e), .write_burst_limit(write_burst_limit),
   .read_burst_limit(read_burst_limit), .line_sync_placement(line_sync_placement),
   .soft_reset_pulse(soft_reset_pulse), .hp_rd_valid(hp_rd_valid), .hp_busy(hp_busy),
   .twowire_clock_out(twowire_clock_out), .twowire_data_out(twowire_data_out)
);

/* File: tb/hpc_host_model.sv */
`timescale 1ns/1ps
module hpc_host_model
(
   input  wire logic       clk_sys,
   output logic            hp_byte_valid,
   output logic [7:0]      hp_byte_data,
   input  wire logic       hp_rd_valid,
   input  wire logic [7:0] hp_rd_data
);
   // idle bus at time zero
   initial
   begin
      hp_byte_valid = 1'b0;
      hp_byte_data  = 8'h00;
   end

   // one byte a cycle, changed on the falling edge
   task automatic send_byte(input logic [7:0] b);
      @(negedge clk_sys);
      hp_byte_valid = 1'b1;
      hp_byte_data  = b;
   endtask

   // single transfers only, never a burst longer than any limit
   task automatic xfer(input logic rd, input logic regsel, input logic [3:0] bdis,
                       input logic [10:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rdat);
      int n;
      n    = 0;
      rdat = 'x;
      send_byte({2'b00, rd, regsel, bdis});
      send_byte({5'h00, ofs[10:8]});
      send_byte(ofs[7:0]);
      for (int i = 0; i < 4 && !rd; i++)
         send_byte(wd[8*i +: 8]);
      @(negedge clk_sys);
      hp_byte_valid = 1'b0;
      hp_byte_data  = ~hp_byte_data; // a released bus keeps no stale byte
      // read bytes arrive lowest first; a short answer leaves unknowns behind
      for (int t = 0; t < 12 && rd && n < 4; t++)
      begin
         @(posedge clk_sys);
         if (hp_rd_valid === 1'b1)
         begin
            rdat[8*n +: 8] = hp_rd_data;
            n++;
         end
      end
   endtask
endmodule

/* File: tb/tb_host_port_control_regs.sv */
`timescale 1ns/1ps
module tb_host_port_control_regs;
   localparam logic [7:0] DEV = 8'ha7; // arbitrary value
   localparam logic [7:0] REV = 8'h3c; // arbitrary value
   localparam logic [3:0] WTAB [4] = '{4'h1, 4'h2, 4'h4, 4'h6};
   localparam logic [3:0] RTAB [4] = '{4'h2, 4'h4, 4'h8, 4'h0};
   localparam logic [4:0] LTAB [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h08, 5'h10, 5'h10};

   logic        clk_sys            = 1'b0;
   logic        rst                = 1'b1;
   logic        internal_irq       = 1'b0;
   logic        external_irq_input = 1'b0;
   logic        agent_sda          = 1'b0;
   logic        hp_byte_valid;
   logic [7:0]  hp_byte_data;
   logic        hp_rd_valid;
   logic [7:0]  hp_rd_data;
   logic        pci_irq_n;
   logic [4:0]  leg;
   logic [3:0]  write_burst_limit;
   logic [3:0]  read_burst_limit;
   logic        line_sync_placement;
   logic        soft_reset_pulse;
   logic        scl_oe;
   logic        sda_oe;
   logic [31:0] rdat;
   logic [14:0] outs;
   int          errors  = 0;
   int          checked = 0;
   int          pulses  = 0;

   always #10 clk_sys = ~clk_sys;

   // pulled-up two-wire lines, low while any party pulls them
   wire logic scl_in = !scl_oe;
   wire logic sda_in = !sda_oe && !agent_sda;
   assign outs = {pci_irq_n, leg, write_burst_limit, read_burst_limit, line_sync_placement};

   // soft reset pulses counted as they happen
   always @(posedge clk_sys)
      if (soft_reset_pulse === 1'b1)
         pulses <= pulses + 1;

   hpc_host_model host_u
   (
      .clk_sys(clk_sys), .hp_byte_valid(hp_byte_valid), .hp_byte_data(hp_byte_data),
      .hp_rd_valid(hp_rd_valid), .hp_rd_data(hp_rd_data)
   );

   hpc_host_port_regs #(.DEVICE_CODE(DEV), .REVISION_CODE(REV)) dut_u
   (
      .clk_sys(clk_sys), .rst(rst), .hp_byte_valid(hp_byte_valid),
      .hp_byte_data(hp_byte_data), .hp_rd_valid(hp_rd_valid), .hp_rd_data(hp_rd_data),
      .hp_busy(), .internal_irq(internal_irq), .external_irq_input(external_irq_input),
      .pci_irq_n(pci_irq_n), .legacy_irq_line_a(leg[0]), .legacy_irq_line_b(leg[1]),
      .legacy_irq_line_c(leg[2]), .legacy_irq_line_d(leg[3]), .legacy_irq_line_e(leg[4]),
      .write_burst_limit(write_burst_limit), .read_burst_limit(read_burst_limit),
      .line_sync_placement(line_sync_placement), .soft_reset_pulse(soft_reset_pulse),
      .twowire_clock_in(scl_in), .twowire_clock_out(), .twowire_clock_oe(scl_oe),
      .twowire_data_in(sda_in), .twowire_data_out(), .twowire_data_oe(sda_oe)
   );

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // derived outputs settle one edge after the register, hence the wait
   task automatic wr(input logic [10:0] ofs, input logic [31:0] d);
      host_u.xfer(1'b0, 1'b1, 4'h0, ofs, d, rdat);
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic rd_chk(input string what, input logic [10:0] ofs, input logic [31:0] exp);
      host_u.xfer(1'b1, 1'b1, 4'h0, ofs, 32'h00000000, rdat);
      check(what, exp, rdat);
   endtask

   task automatic t_reset();
      check("reset outputs", 32'({1'b1, 5'h00, 4'h8, 4'h0, 1'b1}), 32'(outs));
      check("reset oe", 32'h00000000, 32'({scl_oe, sda_oe}));
      rd_chk("id", 11'h000, {16'h0000, REV, DEV});
      rd_chk("ctrl", 11'h020, 32'h000107c8);
      rd_chk("srst", 11'h034, 32'h00000000);
      rd_chk("twi", 11'h060, 32'h00000000);
   endtask

   task automatic t_reserved();
      wr(11'h000, 32'hffffffff);
      rd_chk("id after write", 11'h000, {16'h0000, REV, DEV});
      for (int o = 4; o <= 28; o += 4)
      begin
         wr(11'(o), 32'hffffffff);
         rd_chk("reserved", 11'(o), 32'h00000000);
      end
      host_u.xfer(1'b1, 1'b0, 4'h0, 11'h020, 32'h00000000, rdat);
      check("memory read", 32'h00000000, rdat);
      host_u.xfer(1'b0, 1'b0, 4'h0, 11'h020, 32'h00000000, rdat);
      rd_chk("ctrl after memory write", 11'h020, 32'h000107c8);
   endtask

   task automatic t_limits();
      for (int c = 0; c < 4; c++)
      begin
         wr(11'h020, {16'h0000, 6'h00, c[1:0], c[1:0], 5'h00, 1'b1});
         check("write limit", 32'(WTAB[c]), 32'(write_burst_limit));
         check("read limit", 32'(RTAB[c]), 32'(read_burst_limit));
         check("line sync", 32'h00000000, 32'(line_sync_placement));
         rd_chk("ctrl", 11'h020, {22'h000040, c[1:0], c[1:0], 6'h09});
      end
      wr(11'h020, 32'h000000c0);
      check("fixed write limit", 32'h00000008, 32'(write_burst_limit));
   endtask

   task automatic t_irq();
      for (int s = 0; s < 8; s++)
      begin
         wr(11'h020, {16'h0000, s[2:0], 2'b01, 11'h000});
         internal_irq = 1'b1;
         repeat (2) @(negedge clk_sys);
         check("legacy raised", 32'(LTAB[s]), 32'(leg));
         check("pci raised", 32'h00000000, 32'(pci_irq_n));
         internal_irq = 1'b0;
         repeat (2) @(negedge clk_sys);
         check("legacy cleared", 32'h00000000, 32'({leg, pci_irq_n}) ^ 32'h1);
      end
      wr(11'h020, 32'h00000000);
      internal_irq = 1'b1;
      repeat (2) @(negedge clk_sys);
      check("pci masked", 32'h00000001, 32'(pci_irq_n));
      internal_irq = 1'b0;
      wr(11'h020, 32'h00001000);
      external_irq_input = 1'b1;
      repeat (4) @(negedge clk_sys);
      check("pci external", 32'h00000000, 32'(pci_irq_n));
      wr(11'h020, 32'h00000000);
      check("pci external masked", 32'h00000001, 32'(pci_irq_n));
      external_irq_input = 1'b0;
   endtask

   task automatic t_twowire();
      wr(11'h060, 32'h0000000c);
      check("disabled oe", 32'h00000000, 32'({scl_oe, sda_oe}));
      rd_chk("twi disabled", 11'h060, 32'h00000000);
      agent_sda = 1'b1;
      wr(11'h060, 32'h00000012);
      check("clock low oe", 32'h00000002, 32'({scl_oe, sda_oe}));
      rd_chk("twi samples", 11'h060, 32'h00000012);
      agent_sda = 1'b0;
      wr(11'h060, 32'h00000011);
      check("data low oe", 32'h00000001, 32'({scl_oe, sda_oe}));
      rd_chk("twi samples", 11'h060, 32'h00000015);
      wr(11'h060, 32'h00000013);
      rd_chk("twi released", 11'h060, 32'h0000001f);
      wr(11'h060, 32'h00000000);
   endtask

   task automatic t_soft_rst();
      int n0;
      n0 = pulses;
      wr(11'h020, 32'h00000000);
      wr(11'h034, 32'h00010000);
      repeat (3) @(negedge clk_sys);
      check("soft reset pulses", 32'(n0 + 1), 32'(pulses));
      check("limits after soft reset", 32'({4'h8, 4'h0, 1'b1}), 32'(outs[8:0]));
      rd_chk("ctrl after soft reset", 11'h020, 32'h000107c8);
      host_u.xfer(1'b0, 1'b1, 4'b0010, 11'h020, 32'h0000ff41, rdat);
      rd_chk("byte disabled write", 11'h020, 32'h00010749);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      t_reset();
      t_reserved();
      t_limits();
      t_irq();
      t_twowire();
      t_soft_rst();
      finish_test();
   end

   // watchdog well beyond the expected run of about six hundred cycles
   initial
   begin
      #400000;
      errors++;
      finish_test();
   end
endmodule
